// file: common/charger_mode_control_cfg.svh
/*
 * Constants for the charger mode controller: field reset values, code ranges and timing counts.
 * Assumes a 125 MHz clock; included by its bare name.
 */
`ifndef CHARGER_MODE_CONTROL_CFG_SVH
`define CHARGER_MODE_CONTROL_CFG_SVH

// -----------------------------------------------------------------------------
// clock and timing
// -----------------------------------------------------------------------------
`define CLK_MHZ              125
`define BAD_SRC_WIN_MS       30
`define BAD_SRC_WIN_CYC      (`BAD_SRC_WIN_MS * 1000 * `CLK_MHZ)
`define PRESENCE_SINK_MS     256
`define PRESENCE_SINK_CYC    (`PRESENCE_SINK_MS * 1000 * `CLK_MHZ)
`define PRESENCE_PERIOD_MS   2000
`define PRESENCE_PERIOD_CYC  (`PRESENCE_PERIOD_MS * 1000 * `CLK_MHZ)
`define TOPOFF_MIN_BASE      30
`define MIN_CYC              (60 * 1000 * 1000 * `CLK_MHZ)
`define SEARCH_STEP_CYC      1000

// -----------------------------------------------------------------------------
// voltage thresholds in mV and code ranges
// -----------------------------------------------------------------------------
`define SRC_QUAL_MV          16'h0CE4
`define SRC_OVP_MV           16'h36B0
`define BAD_SRC_MV           16'h0ED8
`define TRICKLE_MV           16'h07D0
`define MIN_INPUT_VOLTAGE_REG_MAX_CODE        7'h5F
`define INPUT_CURRENT_LIMIT_MAX_CODE        6'h3F
`define FAST_CHARGE_CURRENT_MAX_CODE        6'h31
`define BATTERY_TARGET_VOLTAGE_MAX_CODE       7'h51
`define END_CHARGE_CURRENT_MAX_CODE        4'hF
`define TRICKLE_MA           13'h0064
`define TOTAL_RESET_BITS     8'h00

`endif

// file: common/charger_mode_control_pkg.sv
/*
 * Types for the charger mode controller.
 * Assumes the constants header is included by users that need numbers.
 */
package charger_mode_control_pkg;
    typedef enum logic [1:0] {OP_CHARGE, OP_BOOST, OP_HIZ}            op_mode_t;
    typedef enum logic [2:0] {PH_IDLE, PH_TRICKLE, PH_PRE, PH_FAST, PH_EOC} phase_t;
    typedef enum logic [1:0] {SRC_WAIT, SRC_CHECK, SRC_GOOD, SRC_BAD}  src_state_t;
endpackage

// file: rtl/charger_mode_control.sv
/*
 * Digital mode and charge-phase control of a single-cell switching charger with boost.
 * Assumes measured voltages arrive as mV codes synchronous to clk; settings come as ports.
 */
`timescale 1ns/1ps
`include "charger_mode_control_cfg.svh"
module charger_mode_control #(
    parameter int unsigned BAD_SRC_CYC  = `BAD_SRC_WIN_CYC,
    parameter int unsigned SINK_CYC     = `PRESENCE_SINK_CYC,
    parameter int unsigned PERIOD_CYC   = `PRESENCE_PERIOD_CYC,
    parameter int unsigned MINUTE_CYC   = `MIN_CYC,
    parameter int unsigned DEGLITCH_CYC = 16
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] input_rail_mv,
    input  wire logic [15:0] battery_mv,
    input  wire logic [12:0] charge_ma,
    input  wire logic        system_overload,
    input  wire logic        input_droop,
    input  wire logic        warn_input_v,
    input  wire logic        warn_input_i,
    input  wire logic        thermal_regulation_flag,
    input  wire logic [6:0]  min_input_voltage_reg,
    input  wire logic [5:0]  input_current_limit,
    input  wire logic        input_limit_disable,
    input  wire logic [5:0]  fast_charge_current,
    input  wire logic [6:0]  battery_target_voltage,
    input  wire logic [3:0]  end_charge_current,
    input  wire logic [15:0] precharge_threshold,
    input  wire logic [12:0] precharge_current,
    input  wire logic        bad_source_check_off,
    input  wire logic [1:0]  input_limit_source_sel,
    input  wire logic        switch_rate_select,
    input  wire logic        constant_switch_rate,
    input  wire logic        converter_master_enable,
    input  wire logic        charge_enable_bit,
    input  wire logic        charge_inhibit_pin,
    input  wire logic        high_impedance_bit,
    input  wire logic        end_detect_enable,
    input  wire logic [2:0]  end_detect_deglitch,
    input  wire logic        termination_enable,
    input  wire logic [1:0]  topoff_timer_sel,
    input  wire logic        battery_presence_check,
    input  wire logic        boost_select,
    input  wire logic        boost_pin_control,
    input  wire logic        boost_pin,
    input  wire logic        boost_output_route,
    input  wire logic        end_flag_clear,
    output logic [1:0]       op_mode,
    output logic [2:0]       charge_phase,
    output logic             charge_allowed,
    output logic             bad_source,
    output logic             bad_source_sink,
    output logic             battery_switch_on,
    output logic             converter_on,
    output logic             low_power,
    output logic [15:0]      min_input_voltage_reg_target_mv,
    output logic [11:0]      limit_ma,
    output logic             limit_active,
    output logic [12:0]      charge_target_ma,
    output logic [15:0]      battery_target_voltage_mv,
    output logic [9:0]       end_current_ma,
    output logic [1:0]       limit_source,
    output logic [2:0]       warn_status,
    output logic             rate_half,
    output logic             rate_fixed,
    output logic             end_current_flag,
    output logic             int_n,
    output logic             presence_sink,
    output logic             battery_absent,
    output logic             boost_to_input_rail,
    output logic             boost_to_intermediate_node
);
    import charger_mode_control_pkg::*;
    // ---------------------------------------------------------------------
    // target decode
    // ---------------------------------------------------------------------
    logic [6:0]  min_input_voltage_reg_code;
    logic [5:0]  input_current_limit_code;
    logic [5:0]  fast_charge_current_code;
    logic [6:0]  battery_target_voltage_code;
    logic [5:0]  search_code_r;
    logic [5:0]  eff_input_current_limit;
    logic [9:0]  search_cnt_r;

    assign min_input_voltage_reg_code  = (min_input_voltage_reg > `MIN_INPUT_VOLTAGE_REG_MAX_CODE) ? `MIN_INPUT_VOLTAGE_REG_MAX_CODE
                                                                 : min_input_voltage_reg;
    assign input_current_limit_code  = (input_current_limit > `INPUT_CURRENT_LIMIT_MAX_CODE) ? `INPUT_CURRENT_LIMIT_MAX_CODE
                                                               : input_current_limit;
    assign fast_charge_current_code  = (fast_charge_current > `FAST_CHARGE_CURRENT_MAX_CODE) ? `FAST_CHARGE_CURRENT_MAX_CODE
                                                               : fast_charge_current;
    assign battery_target_voltage_code = (battery_target_voltage > `BATTERY_TARGET_VOLTAGE_MAX_CODE) ? `BATTERY_TARGET_VOLTAGE_MAX_CODE
                                                                   : battery_target_voltage;
    assign eff_input_current_limit   = (search_code_r < input_current_limit_code) ? search_code_r : input_current_limit_code;

    always_ff @(posedge clk) begin
        if (rst) begin
            min_input_voltage_reg_target_mv   <= 16'h0F3C;
            battery_target_voltage_mv         <= 16'h0F3C;
            limit_ma         <= 12'h064;
            charge_target_ma <= 13'h0064;
            end_current_ma   <= 10'h064;
        end else begin
            min_input_voltage_reg_target_mv   <= 16'(16'd3900 + 16'd100 * 16'(min_input_voltage_reg_code));
            battery_target_voltage_mv         <= 16'(16'd3900 + 16'd10 * 16'(battery_target_voltage_code));
            limit_ma         <= 12'(12'd100 + 12'd50 * 12'(eff_input_current_limit));
            end_current_ma   <= 10'(10'd100 + 10'd50 * 10'(end_charge_current));
            case (phase_t'(charge_phase))
                PH_TRICKLE: charge_target_ma <= `TRICKLE_MA;
                PH_PRE:     charge_target_ma <= precharge_current;
                default:    charge_target_ma <= 13'(13'd100 + 13'd100 * 13'(fast_charge_current_code));
            endcase
        end
    end

    // input limit search: step down while drooping at the voltage target
    always_ff @(posedge clk) begin
        if (rst) begin
            search_code_r <= `INPUT_CURRENT_LIMIT_MAX_CODE;
            search_cnt_r  <= 10'h000;
            limit_active  <= 1'b0;
        end else begin
            limit_active <= ~input_limit_disable;
            if (!input_droop) begin
                search_code_r <= `INPUT_CURRENT_LIMIT_MAX_CODE;
                search_cnt_r  <= 10'h000;
            end else if (search_cnt_r == 10'(`SEARCH_STEP_CYC - 1)) begin
                search_cnt_r <= 10'h000;
                if (search_code_r > 6'h00)
                    search_code_r <= (search_code_r > input_current_limit_code) ? input_current_limit_code - 6'h01
                                                                 : search_code_r - 6'h01;
            end else begin
                search_cnt_r <= search_cnt_r + 10'h001;
            end
        end
    end

    // ---------------------------------------------------------------------
    // source qualification
    // ---------------------------------------------------------------------
    src_state_t  src_r;
    logic [31:0] src_cnt_r;
    logic        src_ok;

    always_ff @(posedge clk) begin
        if (rst) begin
            src_r     <= SRC_WAIT;
            src_cnt_r <= 32'h00000000;
        end else begin
            case (src_r)
                SRC_WAIT: begin
                    src_cnt_r <= 32'h00000000;
                    if (input_rail_mv > `SRC_QUAL_MV)
                        src_r <= bad_source_check_off ? SRC_GOOD : SRC_CHECK;
                end
                SRC_CHECK: begin
                    src_cnt_r <= src_cnt_r + 32'h00000001;
                    if (input_rail_mv <= `BAD_SRC_MV)
                        src_r <= SRC_BAD;
                    else if (src_cnt_r == BAD_SRC_CYC - 1)
                        src_r <= SRC_GOOD;
                end
                SRC_GOOD, SRC_BAD: begin
                    if (input_rail_mv <= `SRC_QUAL_MV)
                        src_r <= SRC_WAIT;
                end
                default: src_r <= SRC_WAIT;
            endcase
        end
    end
    assign src_ok = (src_r == SRC_GOOD) && (input_rail_mv < `SRC_OVP_MV);

    // ---------------------------------------------------------------------
    // operating mode and boost path
    // ---------------------------------------------------------------------
    logic    boost_req;
    op_mode_t mode_nxt;
    assign boost_req = boost_select && (!boost_pin_control || boost_pin);

    always_comb begin
        if (high_impedance_bit)      mode_nxt = OP_HIZ;
        else if (boost_req)          mode_nxt = OP_BOOST;
        else                         mode_nxt = OP_CHARGE;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_mode                    <= 2'(OP_CHARGE);
            converter_on               <= 1'b0;
            low_power                  <= 1'b0;
            boost_to_input_rail        <= 1'b0;
            boost_to_intermediate_node <= 1'b0;
            rate_half                  <= 1'b0;
            rate_fixed                 <= 1'b0;
            limit_source               <= 2'h0;
            warn_status                <= 3'h0;
            bad_source                 <= 1'b0;
            bad_source_sink            <= 1'b0;
        end else begin
            op_mode      <= 2'(mode_nxt);
            converter_on <= converter_master_enable && (mode_nxt != OP_HIZ);
            low_power    <= (mode_nxt == OP_HIZ);
            boost_to_input_rail <= converter_master_enable && mode_nxt == OP_BOOST
                                   && boost_output_route;
            boost_to_intermediate_node <= converter_master_enable && mode_nxt == OP_BOOST
                                          && !boost_output_route;
            rate_half    <= switch_rate_select;
            rate_fixed   <= constant_switch_rate;
            limit_source <= input_limit_source_sel;
            warn_status  <= {thermal_regulation_flag, warn_input_i, warn_input_v};
            bad_source      <= (src_r == SRC_BAD);
            bad_source_sink <= (src_r == SRC_CHECK);
        end
    end

    // ---------------------------------------------------------------------
    // charge phase
    // ---------------------------------------------------------------------
    phase_t phase_nxt;
    logic   charging_ok;
    logic   done_r;
    assign charging_ok = converter_master_enable && src_ok && mode_nxt == OP_CHARGE
                         && charge_enable_bit && !charge_inhibit_pin;

    always_comb begin
        if (!charging_ok || done_r)                  phase_nxt = PH_IDLE;
        else if (battery_mv < `TRICKLE_MV)           phase_nxt = PH_TRICKLE;
        else if (battery_mv < precharge_threshold)   phase_nxt = PH_PRE;
        else if (battery_mv < battery_target_voltage_mv)              phase_nxt = PH_FAST;
        else                                         phase_nxt = PH_EOC;
    end

    // ---------------------------------------------------------------------
    // end of charge, termination, top-off, presence
    // ---------------------------------------------------------------------
    logic [10:0] degl_cnt_r;
    logic [31:0] tmr_cnt_r;
    logic [5:0]  topoff_min_r;
    logic        topoff_r;
    logic        below_end;
    assign below_end = charge_ma < 13'(end_current_ma);

    always_ff @(posedge clk) begin
        if (rst) begin
            degl_cnt_r       <= 11'h000;
            end_current_flag <= 1'b0;
        end else begin
            if (phase_nxt == PH_EOC && end_detect_enable && below_end) begin
                if (degl_cnt_r != 11'h7FF)
                    degl_cnt_r <= degl_cnt_r + 11'h001;
            end else begin
                degl_cnt_r <= 11'h000;
            end
            if (degl_cnt_r == 11'(DEGLITCH_CYC * (32'(end_detect_deglitch) + 1)))
                end_current_flag <= 1'b1;
            else if (end_flag_clear)
                end_current_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r         <= 1'b0;
            topoff_r       <= 1'b0;
            topoff_min_r   <= 6'h00;
            tmr_cnt_r      <= 32'h00000000;
            presence_sink  <= 1'b0;
            battery_absent <= 1'b0;
        end else if (!charging_ok) begin
            done_r   <= 1'b0;
            topoff_r <= 1'b0;
            presence_sink <= 1'b0;
        end else if (!done_r && !topoff_r) begin
            tmr_cnt_r <= 32'h00000000;
            if (degl_cnt_r == 11'(DEGLITCH_CYC * (32'(end_detect_deglitch) + 1))) begin
                if (topoff_timer_sel != 2'h0) begin
                    topoff_r     <= 1'b1;
                    topoff_min_r <= 6'(`TOPOFF_MIN_BASE + 10 * (topoff_timer_sel - 1));
                end else if (termination_enable) begin
                    done_r <= 1'b1;
                end
            end
        end else if (topoff_r) begin
            if (tmr_cnt_r == MINUTE_CYC - 1) begin
                tmr_cnt_r <= 32'h00000000;
                if (topoff_min_r == 6'h01) begin
                    topoff_r <= 1'b0;
                    done_r   <= termination_enable;
                end
                topoff_min_r <= topoff_min_r - 6'h01;
            end else begin
                tmr_cnt_r <= tmr_cnt_r + 32'h00000001;
            end
        end else begin
            tmr_cnt_r <= (tmr_cnt_r == PERIOD_CYC - 1) ? 32'h00000000
                                                        : tmr_cnt_r + 32'h00000001;
            presence_sink <= battery_presence_check && tmr_cnt_r < SINK_CYC;
            if (presence_sink && battery_mv < battery_target_voltage_mv - 16'h0064)
                battery_absent <= 1'b1;
            else if (!battery_presence_check)
                battery_absent <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            charge_phase      <= 3'(PH_IDLE);
            charge_allowed    <= 1'b0;
            battery_switch_on <= 1'b1;
            int_n             <= 1'b1;
        end else begin
            charge_phase      <= 3'(phase_nxt);
            charge_allowed    <= charging_ok && !done_r;
            battery_switch_on <= (charging_ok && !done_r) || system_overload;
            int_n             <= !end_current_flag;
        end
    end

    // ---------------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------------
    property p_hiz;
        @(posedge clk) disable iff (rst) high_impedance_bit |=> low_power && !converter_on;
    endproperty
    a_hiz: assert property (p_hiz) else $error("hiz not entered");
    property p_master;
        @(posedge clk) disable iff (rst) !converter_master_enable |=> !converter_on;
    endproperty
    a_master: assert property (p_master) else $error("converter on while disabled");
    property p_route;
        @(posedge clk) disable iff (rst) !(boost_to_input_rail && boost_to_intermediate_node);
    endproperty
    a_route: assert property (p_route) else $error("both boost routes");
    property p_int;
        @(posedge clk) disable iff (rst) $rose(end_current_flag) |=> !int_n;
    endproperty
    a_int: assert property (p_int) else $error("interrupt not raised");
    property p_overload;
        @(posedge clk) disable iff (rst) system_overload |=> battery_switch_on;
    endproperty
    a_overload: assert property (p_overload) else $error("switch open on overload");
    property p_ovp;
        @(posedge clk) disable iff (rst) input_rail_mv >= `SRC_OVP_MV |=> !charge_allowed;
    endproperty
    a_ovp: assert property (p_ovp) else $error("charging above ovp");
    property p_trickle;
        @(posedge clk) disable iff (rst)
            charge_phase == 3'(PH_TRICKLE) |=> charge_target_ma == `TRICKLE_MA;
    endproperty
    a_trickle: assert property (p_trickle) else $error("trickle current wrong");
    property p_min_input_voltage_reg;
        @(posedge clk) disable iff (rst) min_input_voltage_reg_target_mv >= 16'h0F3C && min_input_voltage_reg_target_mv <= 16'h3458;
    endproperty
    a_min_input_voltage_reg: assert property (p_min_input_voltage_reg) else $error("min_input_voltage_reg out of range");
    c_boost: cover property (@(posedge clk) op_mode == 2'(OP_BOOST));
    c_eoc:   cover property (@(posedge clk) $rose(end_current_flag));
    c_bad:   cover property (@(posedge clk) bad_source);
endmodule // charger_mode_control

// file: verif/charger_host_model.sv
/*
 * Host-side model: services the interrupt line by pulsing the end-flag clear.
 * Assumes int_n is registered in the clk domain and the clear is taken on the rising clk edge.
 */
`timescale 1ns/1ps
module charger_host_model #(
    parameter int SERVICE_CYC = 10
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic int_n,
    output logic      end_flag_clear
);
    int wait_cnt;
    // a real host reads status late, so the clear comes one pulse after a service delay
    always_ff @(posedge clk) begin
        if (rst || int_n) begin
            wait_cnt       <= 0;
            end_flag_clear <= 1'b0;
        end else begin
            wait_cnt       <= wait_cnt + 1;
            end_flag_clear <= (wait_cnt == SERVICE_CYC);
        end
    end
endmodule // charger_host_model

// file: verif/charger_mode_control_tb_top.sv
/*
 * Self-checking bench: integer reference model compared at every result.
 * Assumes the shortened counts passed below and a host model on the interrupt line.
 */
`timescale 1ns/1ps
module charger_mode_control_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] input_rail_mv, battery_mv, precharge_threshold, min_input_voltage_reg_target_mv, battery_target_voltage_mv;
    logic [12:0] charge_ma, precharge_current, charge_target_ma;
    logic [6:0]  min_input_voltage_reg, battery_target_voltage;
    logic [5:0]  input_current_limit, fast_charge_current;
    logic [3:0]  end_charge_current;
    logic [2:0]  end_detect_deglitch, charge_phase, warn_status;
    logic [1:0]  input_limit_source_sel, topoff_timer_sel, op_mode, limit_source;
    logic [11:0] limit_ma;
    logic [9:0]  end_current_ma;
    logic        system_overload, input_droop, warn_input_v, warn_input_i, thermal_regulation_flag;
    logic        input_limit_disable, bad_source_check_off, switch_rate_select, constant_switch_rate;
    logic        converter_master_enable, charge_enable_bit, charge_inhibit_pin, high_impedance_bit;
    logic        end_detect_enable, termination_enable, battery_presence_check, boost_select;
    logic        boost_pin_control, boost_pin, boost_output_route, end_flag_clear, int_n;
    logic        charge_allowed, bad_source, bad_source_sink, battery_switch_on, converter_on;
    logic        low_power, limit_active, rate_half, rate_fixed, end_current_flag, presence_sink;
    logic        battery_absent, boost_to_input_rail, boost_to_intermediate_node;
    logic [4:0]  rows [5] = '{5'h10, 5'h09, 5'h08, 5'h0C, 5'h0F};
    int          mismatches = 0;
    int          compares = 0;
    int unsigned seed = 9640;
    int          c [5];
    int          m;

    charger_mode_control #(.BAD_SRC_CYC(50), .SINK_CYC(20), .PERIOD_CYC(100),
        .MINUTE_CYC(10), .DEGLITCH_CYC(4)) u_charger_mode_control (.*);
    charger_host_model u_charger_host_model (.clk(clk), .rst(rst), .int_n(int_n),
        .end_flag_clear(end_flag_clear));

    always #4 clk = ~clk;

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // tests
    // -------------------------------------------------------------------------
    initial begin
        {input_rail_mv, battery_mv, precharge_threshold, charge_ma, precharge_current,
         min_input_voltage_reg, battery_target_voltage, input_current_limit,
         fast_charge_current, end_charge_current, end_detect_deglitch, input_limit_source_sel,
         topoff_timer_sel, system_overload, input_droop, warn_input_v, warn_input_i,
         thermal_regulation_flag, input_limit_disable, bad_source_check_off, switch_rate_select,
         constant_switch_rate, converter_master_enable, charge_enable_bit, charge_inhibit_pin,
         high_impedance_bit, end_detect_enable, termination_enable, battery_presence_check,
         boost_select, boost_pin_control, boost_pin, boost_output_route} = '0;
        tick(4);
        rst = 1'b0;
        chk("op_mode", 16'h0000, op_mode);
        chk("int_n", 16'h0001, int_n);
        {converter_master_enable, charge_enable_bit} = 2'h3;
        {input_rail_mv, battery_mv, precharge_threshold} = {16'h1388, 16'h0ED8, 16'h0BB8};
        tick(3);
        chk("bad_source_sink", 16'h0001, bad_source_sink);
        tick(60);
        chk("charge_allowed", 16'h0001, charge_allowed);
        chk("bad_source", 16'h0000, bad_source);
        $display("done qualification");
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 5; k++)
                c[k] = (i == 0) ? 1000 : int'(xs() % 1000);
            c[0] %= 96; c[1] %= 64; c[2] %= 50; c[3] %= 82; c[4] %= 16;
            min_input_voltage_reg = 7'(c[0]);
            input_current_limit = 6'(c[1]);
            fast_charge_current = 6'(c[2]);
            battery_target_voltage = 7'(c[3]);
            end_charge_current = 4'(c[4]);
            tick(3);
            chk("min_input_voltage_reg_target_mv", 16'(3900 + 100 * c[0]), min_input_voltage_reg_target_mv);
            chk("limit_ma", 16'(100 + 50 * c[1]), limit_ma);
            chk("charge_target_ma", 16'(100 + 100 * c[2]), charge_target_ma);
            chk("battery_target_voltage_mv", 16'(3900 + 10 * c[3]), battery_target_voltage_mv);
            chk("end_current_ma", 16'(100 + 50 * c[4]), end_current_ma);
        end
        // droop at full limit: one step down after the 1000-cycle search interval
        {input_current_limit, input_droop} = {6'h3F, 1'b1};
        tick(1002);
        chk("limit_ma", 16'h0C80, limit_ma);
        input_droop = 1'b0;
        $display("done targets");
        {battery_target_voltage, end_charge_current} = '0;
        foreach (c[k]) if (k < 4) begin
            battery_mv = (k == 0) ? 16'h05DC : (k == 1) ? 16'h09C4 : (k == 2) ? 16'h0ED8 : 16'h0F3C;
            tick(3);
            chk("charge_phase", 16'(k + 1), charge_phase);
        end
        $display("done phases");
        {end_detect_enable, termination_enable, battery_presence_check} = 3'h7;
        charge_ma = 13'h0032;
        tick(8);
        chk("end_current_flag", 16'h0001, end_current_flag);
        chk("int_n", 16'h0000, int_n);
        chk("battery_switch_on", 16'h0000, battery_switch_on);
        chk("presence_sink", 16'h0001, presence_sink);
        chk("battery_absent", 16'h0000, battery_absent);
        charge_ma = 13'h01F4;
        tick(20);
        chk("int_n", 16'h0001, int_n);
        $display("done end of charge");
        foreach (rows[i]) begin
            {high_impedance_bit, boost_select, boost_pin_control, boost_pin, boost_output_route} = rows[i];
            switch_rate_select = xs() % 2;
            constant_switch_rate = xs() % 2;
            input_limit_disable = xs() % 2;
            input_limit_source_sel = 2'(xs());
            {thermal_regulation_flag, warn_input_i, warn_input_v} = 3'(xs());
            m = rows[i][4] ? 2 : (rows[i][3] && (!rows[i][2] || rows[i][1])) ? 1 : 0;
            tick(3);
            chk("op_mode", 16'(m), op_mode);
            chk("to_input_rail", 16'(m == 1 && rows[i][0]), boost_to_input_rail);
            chk("to_mid_node", 16'(m == 1 && !rows[i][0]), boost_to_intermediate_node);
            chk("low_power", 16'(rows[i][4]), low_power);
            chk("rate_half", 16'(switch_rate_select), rate_half);
            chk("rate_fixed", 16'(constant_switch_rate), rate_fixed);
            chk("limit_active", 16'(!input_limit_disable), limit_active);
            chk("limit_source", 16'(input_limit_source_sel), limit_source);
            chk("warn_status", 16'({thermal_regulation_flag, warn_input_i, warn_input_v}),
                warn_status);
        end
        converter_master_enable = 1'b0;
        tick(3);
        chk("converter_on", 16'h0000, converter_on);
        $display("done modes");
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule // charger_mode_control_tb_top
